// >>> core/amx_pkg.sv
// package: register addresses, field layout, reset values and source codes for the input mux block
package amx_pkg;
   localparam logic [7:0] AMX_ADDR_INPUT_SELECT = 8'hC6;
   localparam logic [7:0] AMX_ADDR_FAST_LOW = 8'hFC;
   localparam logic [7:0] AMX_ADDR_FAST_MIDDLE = 8'hFD;
   localparam logic [7:0] AMX_ADDR_FAST_HIGH = 8'hFE;
   localparam int AMX_POS_SEL_LSB = 4;
   localparam int AMX_NEG_SEL_LSB = 0;
   localparam int AMX_SEL_WIDTH = 4;
   localparam int AMX_PIN_COUNT = 8;
   localparam int AMX_SOURCE_COUNT = 10;
   localparam logic [7:0] AMX_RESET_INPUT_SELECT = 8'h00;
   localparam logic [7:0] AMX_RESET_FAST_BYTE = 8'h00;
   localparam logic [3:0] AMX_CODE_PIN_LAST = 4'h7;
   localparam logic [3:0] AMX_CODE_TEMP_SENSOR = 4'hF;
   // one-hot source vector: bits 7..0 pins, 8 ground, 9 sensor
   localparam int AMX_SRC_GROUND = 8;
   localparam int AMX_SRC_SENSOR = 9;
   localparam int AMX_FAST_BYTE_COUNT = 3;
endpackage

// >>> core/amx_result_bus.sv
// interface: carries a completed fast-filter result word to its byte store
interface amx_result_bus;
   logic load;
   logic [23:0] word;
   logic [7:0] wr_data;
   logic [1:0] wr_index;
   logic wr_en;
   logic [1:0] rd_index;
   logic [7:0] rd_data;
   modport ctrl (output load, output word, output wr_data, output wr_index, output wr_en,
      output rd_index, input rd_data);
   modport store (input load, input word, input wr_data, input wr_index, input wr_en,
      input rd_index, output rd_data);
endinterface

// >>> core/amx_result_store.sv
// byte store for the three fast-filter result bytes, registered read data
module amx_result_store
   import amx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   amx_result_bus.store bus
);
   typedef struct packed {
      logic [AMX_FAST_BYTE_COUNT-1:0][7:0] bytes;
      logic [7:0] rd_data;
   } amx_store_type;

   amx_store_type state;
   amx_store_type next_state;

   always_comb begin
      next_state = state;
      // whole word loads at once so the bytes stay coherent
      if (bus.load) begin
         next_state.bytes = bus.word;
      end else if (bus.wr_en && bus.wr_index < 2'(AMX_FAST_BYTE_COUNT)) begin
         next_state.bytes[bus.wr_index] = bus.wr_data;
      end
      if (bus.rd_index < 2'(AMX_FAST_BYTE_COUNT)) begin
         next_state.rd_data = state.bytes[bus.rd_index];
      end else begin
         next_state.rd_data = 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state.bytes <= {AMX_FAST_BYTE_COUNT{AMX_RESET_FAST_BYTE}};
         state.rd_data <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   assign bus.rd_data = state.rd_data;
endmodule

// >>> core/amx_input_mux.sv
// top: input mux select register, source decode, fast result byte registers
// Function
// - fast result bits 15..8 at address FD
// - fast result bits 7..0 at address FC
// - fast result bits 23..16 at address FE
// - separate select fields for each input
// - each input picks one of ten sources
// - one register at C6 holds both selects
// - positive field bits 7..4, codes 0-7 pins
// - code F sensor, other unused codes ground
// - negative field bits 3..0, same codes
// - sensor enabled whenever either field selects it
module amx_input_mux
   import amx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic conv_done,
   input wire logic [23:0] fast_result,
   output logic [7:0] sfr_rdata,
   output logic [AMX_SOURCE_COUNT-1:0] positive_source,
   output logic [AMX_SOURCE_COUNT-1:0] negative_source,
   output logic temp_sensor_enable
);
   typedef struct packed {
      logic [7:0] input_select;
      logic [AMX_SOURCE_COUNT-1:0] pos_src;
      logic [AMX_SOURCE_COUNT-1:0] neg_src;
      logic sensor_en;
      logic rd_pending;
      logic rd_is_store;
      logic [7:0] rd_local;
      logic [7:0] rdata;
   } amx_top_type;

   amx_top_type state;
   amx_top_type next_state;
   amx_result_bus rbus();
   logic [7:0] sel_next;

   amx_result_store u_store (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus(rbus)
   );

   // one-hot decode of a four-bit select code
   function automatic logic [AMX_SOURCE_COUNT-1:0] amx_decode(input logic [3:0] code);
      logic [AMX_SOURCE_COUNT-1:0] src;
      src = '0;
      if (code <= AMX_CODE_PIN_LAST) begin
         src[code[2:0]] = 1'b1;
      end else if (code == AMX_CODE_TEMP_SENSOR) begin
         src[AMX_SRC_SENSOR] = 1'b1;
      end else begin
         src[AMX_SRC_GROUND] = 1'b1;
      end
      return src;
   endfunction

   // byte index of a result address, 3 when not a result byte
   function automatic logic [1:0] amx_result_index(input logic [7:0] addr);
      logic [1:0] idx;
      idx = 2'd3;
      if (addr == AMX_ADDR_FAST_LOW) begin
         idx = 2'd0;
      end else if (addr == AMX_ADDR_FAST_MIDDLE) begin
         idx = 2'd1;
      end else if (addr == AMX_ADDR_FAST_HIGH) begin
         idx = 2'd2;
      end
      return idx;
   endfunction

   assign rbus.load = conv_done;
   assign rbus.word = fast_result;
   assign rbus.wr_data = sfr_wdata;
   assign rbus.wr_index = amx_result_index(sfr_addr);
   assign rbus.wr_en = sfr_wr && !conv_done;
   assign rbus.rd_index = amx_result_index(sfr_addr);

   always_comb begin
      next_state = state;
      sel_next = state.input_select;
      if (sfr_wr && sfr_addr == AMX_ADDR_INPUT_SELECT) begin
         sel_next = sfr_wdata;
      end
      next_state.input_select = sel_next;
      // switch controls follow the written value on the next edge
      next_state.pos_src = amx_decode(sel_next[AMX_POS_SEL_LSB +: AMX_SEL_WIDTH]);
      next_state.neg_src = amx_decode(sel_next[AMX_NEG_SEL_LSB +: AMX_SEL_WIDTH]);
      next_state.sensor_en =
         sel_next[AMX_POS_SEL_LSB +: AMX_SEL_WIDTH] == AMX_CODE_TEMP_SENSOR ||
         sel_next[AMX_NEG_SEL_LSB +: AMX_SEL_WIDTH] == AMX_CODE_TEMP_SENSOR;
      // read: address taken now, data on the second edge after
      next_state.rd_pending = sfr_rd;
      next_state.rd_is_store = amx_result_index(sfr_addr) != 2'd3;
      next_state.rd_local = (sfr_addr == AMX_ADDR_INPUT_SELECT) ? state.input_select : 8'h00;
      if (state.rd_pending) begin
         next_state.rdata = state.rd_is_store ? rbus.rd_data : state.rd_local;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state.input_select <= AMX_RESET_INPUT_SELECT;
         state.pos_src <= 10'h001;
         state.neg_src <= 10'h001;
         state.sensor_en <= 1'b0;
         state.rd_pending <= 1'b0;
         state.rd_is_store <= 1'b0;
         state.rd_local <= 8'h00;
         state.rdata <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   assign sfr_rdata = state.rdata;
   assign positive_source = state.pos_src;
   assign negative_source = state.neg_src;
   assign temp_sensor_enable = state.sensor_en;
endmodule

// >>> testbench/amx_input_mux_assertions.sv
// checker: decode, sensor enable and read properties of the input mux
module amx_input_mux_assertions
   import amx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic conv_done,
   input wire logic [23:0] fast_result,
   input wire logic [7:0] sfr_rdata,
   input wire logic [AMX_SOURCE_COUNT-1:0] positive_source,
   input wire logic [AMX_SOURCE_COUNT-1:0] negative_source,
   input wire logic temp_sensor_enable
);
   logic wr_q;
   logic [7:0] wd_q;
   logic [23:0] fr_q;
   always_ff @(posedge clk_sys) begin
      wr_q <= rst_n && sfr_wr && sfr_addr == 8'hC6;
      wd_q <= sfr_wdata;
      if (conv_done) fr_q <= fast_result;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_rd_mid;
      conv_done ##1 (sfr_rd && sfr_addr == 8'hFD && !conv_done && !sfr_wr)
         ##1 (!conv_done && !sfr_wr)[*3];
   endsequence
   a_pos_pin: assert property (wr_q && !wd_q[7] |-> positive_source == 10'h1 << wd_q[7:4])
      else $error("positive pin");
   a_neg_pin: assert property (wr_q && !wd_q[3] |-> negative_source == 10'h1 << wd_q[3:0])
      else $error("negative pin");
   a_sensor_code: assert property (wr_q && &wd_q[7:4] |-> positive_source == 10'h200)
      else $error("sensor code");
   a_gnd_code: assert property (wr_q && wd_q[3] && ~&wd_q[3:0] |-> negative_source == 10'h100)
      else $error("ground code");
   a_temp_on: assert property (
      temp_sensor_enable == (positive_source[9] | negative_source[9])) else $error("sensor on");
   a_src_hold: assert property (!(sfr_wr && sfr_addr == 8'hC6) |=>
      $stable(positive_source) && $stable(negative_source)) else $error("source moved");
   a_rd_unmap: assert property (sfr_rd && !(sfr_addr inside {8'hC6, 8'hFC, 8'hFD, 8'hFE})
      |-> ##2 sfr_rdata == 8'h00) else $error("unmapped read");
   a_conv_mid: assert property (s_rd_mid |-> sfr_rdata == fr_q[15:8])
      else $error("middle byte");
endmodule
bind amx_input_mux amx_input_mux_assertions u_amx_input_mux_assertions (.*);

// >>> testbench/amx_input_mux_tb.sv
// testbench: select codes, result bytes and register reads of the input mux
module amx_input_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, conv_done = 1'h0;
   logic temp_sensor_enable;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [23:0] fast_result = 24'h000000;
   logic [9:0] positive_source, negative_source;
   logic [9:0] exp_src [16] = '{10'h1, 10'h2, 10'h4, 10'h8, 10'h10, 10'h20, 10'h40, 10'h80,
      10'h100, 10'h100, 10'h100, 10'h100, 10'h100, 10'h100, 10'h100, 10'h200};
   int error_cnt = 0, n_tests = 0, cyc = 0;
   always #4 clk_sys = ~clk_sys;
   amx_input_mux u_amx_input_mux (.*);
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one access: write when w is high, else read and compare with d
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {sfr_wr, sfr_rd, conv_done, sfr_addr, sfr_wdata} <= {w, !w, 1'h0, a, d};
      @(posedge clk_sys);
      {sfr_wr, sfr_rd} <= 2'h0;
      if (!w) repeat (2) @(posedge clk_sys);
      #1 if (!w) chk(10'(sfr_rdata), 10'(d));
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'h1;
      acc(0, 8'hFD, 8'h00);
      for (int i = 0; i < 16; i++) begin
         acc(1, 8'hC6, {4'(i), 4'(15 - i)});
         chk(positive_source, exp_src[i]);
         chk(negative_source, exp_src[15 - i]);
         chk(10'(temp_sensor_enable), 10'(i == 0 || i == 15));
         acc(0, 8'hC6, {4'(i), 4'(15 - i)});
      end
      $display("select test done");
      @(posedge clk_sys);
      {conv_done, fast_result} <= {1'h1, 24'hA5C33C};
      acc(0, 8'hFD, 8'hC3);
      acc(0, 8'hFE, 8'hA5);
      acc(0, 8'hFC, 8'h3C);
      acc(1, 8'hFC, 8'h5A);
      acc(0, 8'hFC, 8'h5A);
      // conversion and software write in one cycle: conversion wins
      @(posedge clk_sys);
      {conv_done, sfr_wr, sfr_addr, sfr_wdata, fast_result} <= {2'h3, 8'hFD, 8'hEE, 24'h123456};
      acc(0, 8'hFD, 8'h34);
      $display("result test done");
      acc(1, 8'hC7, 8'h55);
      acc(0, 8'hC6, 8'hF0);
      acc(0, 8'hC7, 8'h00);
      $display("unmapped test done");
      // single-ended: positive pin 3 against grounded negative input
      acc(1, 8'hC6, 8'h38);
      chk(positive_source, 10'h008);
      chk(negative_source, 10'h100);
      chk(10'(temp_sensor_enable), 10'h0);
      acc(1, 8'hC6, 8'hFF);
      chk(10'(temp_sensor_enable), 10'h1);
      $display("single-ended test done");
      // reset in mid-run returns sources, sensor enable and bytes to idle
      @(posedge clk_sys);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      #1 chk(positive_source, 10'h001);
      chk(negative_source, 10'h001);
      chk(10'(temp_sensor_enable), 10'h0);
      acc(0, 8'hC6, 8'h00);
      acc(0, 8'hFE, 8'h00);
      $display("reset test done");
      tally_and_finish();
   end
endmodule
